// ==== rtl/asds_regs.svh ====
// How it works
// - Carry input to the adder on ADDC, SUBB and RSUBB is the carry flag left by the previous operation.
// - Subtract with borrow gives X-Y+C-1, reversed form gives Y-X+C-1.
// - Saturation mode set by commands or mode bit 3; off after reset.
// - Saturating result takes max positive or sign-only negative on overflow, by carry.
// - Saturation stays on for every later operation until disabled.
// - Only the result register saturates; feedback wraps, flags follow saturated value.
// - Sticky overflow set by commands or mode bit 2; off after reset.
// - Sticky overflow holds until a zero is written to flag bit 2.
// - All flags register at the end of the executing cycle.
// - Divide takes 32-bit dividend, 16-bit divisor, 16 quotient bits over 16 steps.
// - Sign step: quotient sign is XOR of sign bits, to flag and y0 bit 0.
// - Sign step passes Y, left shifts the feedback and y0 register pair.
// - Quotient step adds divisor if quotient flag set, else subtracts; offset load.
// - Quotient flag is divisor MSB XOR output MSB; inverse shifts into y0.
// - Zero flag is NOR of all result bits.
// - Negative flag is the result sign bit.
// - Overflow flag is XOR of carries out of the top two adder stages.
// - Carry flag is carry out of the top adder stage.
// - X-sign flag takes the X sign bit, only on absolute value.
// - Quotient flag changes only on the two divide steps.
`ifndef ASDS_REGS_SVH
`define ASDS_REGS_SVH
// Register offsets
`define ASDS_ADDR_X0    4'h0
`define ASDS_ADDR_X1    4'h1
`define ASDS_ADDR_Y0    4'h2
`define ASDS_ADDR_Y1    4'h3
`define ASDS_ADDR_RES   4'h4
`define ASDS_ADDR_FB    4'h5
`define ASDS_ADDR_FLAGS 4'h6
`define ASDS_ADDR_MODE  4'h7
// Flag register bit positions
`define ASDS_FLAG_ZERO  0
`define ASDS_FLAG_NEG   1
`define ASDS_FLAG_OVF   2
`define ASDS_FLAG_CARRY 3
`define ASDS_FLAG_XSIGN 4
`define ASDS_FLAG_QUOT  5
// Mode register bit positions
`define ASDS_MODE_STICKY 2
`define ASDS_MODE_SAT    3
// Saturation values and reset values
`define ASDS_SAT_POS    16'h7FFF
`define ASDS_SAT_NEG    16'h8000
`define ASDS_RST_WORD   16'h0000
`define ASDS_RST_FLAGS  6'h00
`endif

// ==== rtl/asds_pkg.sv ====
package asds_pkg;
   // Operation codes from the sequencer
   typedef enum logic [4:0] {
      ASDS_OP_NOP    = 5'h00,
      ASDS_OP_ADD    = 5'h01,
      ASDS_OP_ADDC   = 5'h02,
      ASDS_OP_SUB    = 5'h03,
      ASDS_OP_SUBB   = 5'h04,
      ASDS_OP_RSUB   = 5'h05,
      ASDS_OP_RSUBB  = 5'h06,
      ASDS_OP_NEGX   = 5'h07,
      ASDS_OP_NEGY   = 5'h08,
      ASDS_OP_INCY   = 5'h09,
      ASDS_OP_DECY   = 5'h0A,
      ASDS_OP_PASSX  = 5'h0B,
      ASDS_OP_PASSY  = 5'h0C,
      ASDS_OP_ZERO   = 5'h0D,
      ASDS_OP_ABSX   = 5'h0E,
      ASDS_OP_AND    = 5'h0F,
      ASDS_OP_OR     = 5'h10,
      ASDS_OP_XOR    = 5'h11,
      ASDS_OP_NOTX   = 5'h12,
      ASDS_OP_NOTY   = 5'h13,
      ASDS_OP_DIVIDE_SIGN_STEP   = 5'h14,
      ASDS_OP_DIVIDE_QUOTIENT_STEP   = 5'h15
   } asds_op_e;
   // Operand sources
   typedef enum logic [1:0] {
      ASDS_XS_X0 = 2'h0,
      ASDS_XS_X1 = 2'h1,
      ASDS_XS_RB = 2'h2,
      ASDS_XS_RES = 2'h3
   } asds_xsel_e;
   typedef enum logic [1:0] {
      ASDS_YS_Y0 = 2'h0,
      ASDS_YS_Y1 = 2'h1,
      ASDS_YS_FB = 2'h2
   } asds_ysel_e;
   // Destination of the result
   typedef enum logic [1:0] {
      ASDS_DST_NONE = 2'h0,
      ASDS_DST_RES = 2'h1,
      ASDS_DST_FB = 2'h2
   } asds_dst_e;
   // Mode command
   typedef enum logic [2:0] {
      ASDS_MC_NONE    = 3'b001,
      ASDS_MC_SET     = 3'b010,
      ASDS_MC_CLEAR   = 3'b100
   } asds_mc_e;
   // Whole state of the unit
   typedef struct packed {
      logic [15:0] x_operand_reg0;
      logic [15:0] x_operand_reg1;
      logic [15:0] y_operand_reg0;
      logic [15:0] y_operand_reg1;
      logic [15:0] alu_result_reg;
      logic [15:0] alu_feedback_reg;
      logic zero_flag;
      logic negative_flag;
      logic overflow_flag;
      logic carry_flag;
      logic x_sign_flag;
      logic quotient_flag;
      logic result_saturation_mode;
      logic sticky_overflow_mode;
      logic [15:0] rdata;
   } asds_state_s;
endpackage

// ==== rtl/asds_alu.sv ====
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "asds_regs.svh"
module asds_alu (
   input wire logic mclk,
   input wire logic reset,
   input wire logic op_valid,
   input wire asds_pkg::asds_op_e op,
   input wire asds_pkg::asds_xsel_e x_sel,
   input wire asds_pkg::asds_ysel_e y_sel,
   input wire asds_pkg::asds_dst_e dst,
   input wire logic [15:0] r_bus,
   input wire asds_pkg::asds_mc_e sat_cmd,
   input wire asds_pkg::asds_mc_e sticky_cmd,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   output logic [15:0] result_out,
   output logic [5:0] flags_out,
   output logic sat_mode_out,
   output logic sticky_mode_out
);
   import asds_pkg::*;

   // ***************************************************
   // Helpers
   // ***************************************************
   // Adder with carry out of top two stages
   function automatic logic [17:0] add16(input logic [15:0] a, input logic [15:0] b,
                                          input logic cin);
      logic [15:0] low;
      logic c14;
      logic [1:0] top;
      {c14, low[14:0]} = {1'b0, a[14:0]} + {1'b0, b[14:0]} + {15'h0000, cin};
      top = {1'b0, a[15]} + {1'b0, b[15]} + {1'b0, c14};
      low[15] = top[0];
      return {top[1], c14, low};
   endfunction

   function automatic logic [15:0] mode_word(input logic sat, input logic sticky);
      logic [15:0] w;
      w = `ASDS_RST_WORD;
      w[`ASDS_MODE_SAT] = sat;
      w[`ASDS_MODE_STICKY] = sticky;
      return w;
   endfunction

   asds_state_s st_r;
   asds_state_s st_nxt;

   // ***************************************************
   // Operand selection and arithmetic
   // ***************************************************
   logic [15:0] xin;
   logic [15:0] yin;
   logic [15:0] divisor;
   logic [17:0] sum;
   logic [15:0] raw;
   logic arith;
   logic quot_bit;

   // Pick operands from the active sources
   always_comb begin
      case (x_sel)
         ASDS_XS_X0: xin = st_r.x_operand_reg0;
         ASDS_XS_X1: xin = st_r.x_operand_reg1;
         ASDS_XS_RES: xin = st_r.alu_result_reg;
         default: xin = r_bus;
      endcase
      case (y_sel)
         ASDS_YS_Y1: yin = st_r.y_operand_reg1;
         ASDS_YS_FB: yin = st_r.alu_feedback_reg;
         default: yin = st_r.y_operand_reg0;
      endcase
   end

   assign divisor = xin;

   // Function decode; carry input of ADDC, SUBB and RSUBB is the stored carry flag
   always_comb begin
      sum = {2'b00, 16'h0000};
      arith = 1'b1;
      raw = 16'h0000;
      case (op)
         ASDS_OP_ADD: sum = add16(xin, yin, 1'b0);
         ASDS_OP_ADDC: sum = add16(xin, yin, st_r.carry_flag);
         ASDS_OP_SUB: sum = add16(xin, ~yin, 1'b1);
         ASDS_OP_SUBB: sum = add16(xin, ~yin, st_r.carry_flag);
         ASDS_OP_RSUB: sum = add16(yin, ~xin, 1'b1);
         ASDS_OP_RSUBB: sum = add16(yin, ~xin, st_r.carry_flag);
         ASDS_OP_NEGX: sum = add16(16'h0000, ~xin, 1'b1);
         ASDS_OP_NEGY: sum = add16(16'h0000, ~yin, 1'b1);
         ASDS_OP_INCY: sum = add16(yin, 16'h0000, 1'b1);
         ASDS_OP_DECY: sum = add16(yin, 16'hFFFF, 1'b0);
         ASDS_OP_PASSX: sum = add16(xin, 16'h0000, 1'b0);
         ASDS_OP_PASSY: sum = add16(yin, 16'h0000, 1'b0);
         ASDS_OP_ZERO: sum = add16(16'h0000, 16'h0000, 1'b0);
         ASDS_OP_ABSX: sum = xin[15] ? add16(16'h0000, ~xin, 1'b1)
                                     : add16(xin, 16'h0000, 1'b0);
         ASDS_OP_DIVIDE_SIGN_STEP: sum = add16(yin, 16'h0000, 1'b0);
         ASDS_OP_DIVIDE_QUOTIENT_STEP: sum = st_r.quotient_flag ? add16(yin, divisor, 1'b0)
                                                : add16(yin, ~divisor, 1'b1);
         ASDS_OP_AND: begin
            arith = 1'b0;
            raw = xin & yin;
         end
         ASDS_OP_OR: begin
            arith = 1'b0;
            raw = xin | yin;
         end
         ASDS_OP_XOR: begin
            arith = 1'b0;
            raw = xin ^ yin;
         end
         ASDS_OP_NOTX: begin
            arith = 1'b0;
            raw = ~xin;
         end
         ASDS_OP_NOTY: begin
            arith = 1'b0;
            raw = ~yin;
         end
         default: arith = 1'b0;
      endcase
      if (arith) begin
         raw = sum[15:0];
      end
   end

   // ***************************************************
   // Next state
   // ***************************************************
   // Flags and saturation are computed from this cycle's output
   always_comb begin
      logic ovf;
      logic cry;
      logic [15:0] sat_val;
      logic [15:0] fb_word;
      logic qflag;
      logic [15:0] mw;
      ovf = 1'b0;
      cry = 1'b0;
      sat_val = 16'h0000;
      fb_word = 16'h0000;
      qflag = 1'b0;
      mw = 16'h0000;
      st_nxt = st_r;
      st_nxt.rdata = 16'h0000;
      quot_bit = 1'b0;
      ovf = arith & (sum[17] ^ sum[16]);
      cry = arith & sum[17];
      // Saturation follows mode, not the instruction
      // Flags see the saturated word even when the feedback register wraps
      if (st_r.result_saturation_mode && ovf) begin
         sat_val = cry ? `ASDS_SAT_NEG : `ASDS_SAT_POS;
      end else begin
         sat_val = raw;
      end
      // Command-driven mode changes, reset leaves both off
      if (sat_cmd == ASDS_MC_SET) st_nxt.result_saturation_mode = 1'b1;
      if (sat_cmd == ASDS_MC_CLEAR) st_nxt.result_saturation_mode = 1'b0;
      if (sticky_cmd == ASDS_MC_SET) st_nxt.sticky_overflow_mode = 1'b1;
      if (sticky_cmd == ASDS_MC_CLEAR) st_nxt.sticky_overflow_mode = 1'b0;
      if (op_valid && op != ASDS_OP_NOP) begin
         // Flags land at the end of the executing cycle
         st_nxt.zero_flag = ~|sat_val;
         st_nxt.negative_flag = sat_val[15];
         st_nxt.carry_flag = cry;
         st_nxt.overflow_flag = ovf | (st_r.sticky_overflow_mode & st_r.overflow_flag);
         if (op == ASDS_OP_ABSX) st_nxt.x_sign_flag = xin[15];
         if (op == ASDS_OP_DIVIDE_SIGN_STEP) begin
            qflag = divisor[15] ^ yin[15];
            st_nxt.quotient_flag = qflag;
            st_nxt.y_operand_reg0 = {st_r.y_operand_reg0[14:0], qflag};
            fb_word = {raw[14:0], st_r.y_operand_reg0[15]};
            st_nxt.alu_feedback_reg = fb_word;
         end else if (op == ASDS_OP_DIVIDE_QUOTIENT_STEP) begin
            qflag = divisor[15] ^ raw[15];
            quot_bit = ~qflag;
            st_nxt.quotient_flag = qflag;
            st_nxt.y_operand_reg0 = {st_r.y_operand_reg0[14:0], quot_bit};
            st_nxt.alu_feedback_reg = {raw[14:0], st_r.y_operand_reg0[15]};
         end else if (dst == ASDS_DST_RES) begin
            st_nxt.alu_result_reg = sat_val;
         end else if (dst == ASDS_DST_FB) begin
            st_nxt.alu_feedback_reg = raw;
         end
      end
      // Register port writes; a direct write of the flags wins
      if (wr) begin
         case (addr)
            `ASDS_ADDR_X0: st_nxt.x_operand_reg0 = wdata;
            `ASDS_ADDR_X1: st_nxt.x_operand_reg1 = wdata;
            `ASDS_ADDR_Y0: st_nxt.y_operand_reg0 = wdata;
            `ASDS_ADDR_Y1: st_nxt.y_operand_reg1 = wdata;
            `ASDS_ADDR_RES: st_nxt.alu_result_reg = wdata;
            `ASDS_ADDR_FB: st_nxt.alu_feedback_reg = wdata;
            `ASDS_ADDR_FLAGS: begin
               st_nxt.zero_flag = wdata[`ASDS_FLAG_ZERO];
               st_nxt.negative_flag = wdata[`ASDS_FLAG_NEG];
               st_nxt.overflow_flag = wdata[`ASDS_FLAG_OVF];
               st_nxt.carry_flag = wdata[`ASDS_FLAG_CARRY];
               st_nxt.x_sign_flag = wdata[`ASDS_FLAG_XSIGN];
               st_nxt.quotient_flag = wdata[`ASDS_FLAG_QUOT];
            end
            `ASDS_ADDR_MODE: begin
               st_nxt.sticky_overflow_mode = wdata[`ASDS_MODE_STICKY];
               st_nxt.result_saturation_mode = wdata[`ASDS_MODE_SAT];
            end
            default: ;
         endcase
      end
      // Read data reflect the state before this cycle
      if (rd) begin
         mw = mode_word(st_r.result_saturation_mode, st_r.sticky_overflow_mode);
         case (addr)
            `ASDS_ADDR_X0: st_nxt.rdata = st_r.x_operand_reg0;
            `ASDS_ADDR_X1: st_nxt.rdata = st_r.x_operand_reg1;
            `ASDS_ADDR_Y0: st_nxt.rdata = st_r.y_operand_reg0;
            `ASDS_ADDR_Y1: st_nxt.rdata = st_r.y_operand_reg1;
            `ASDS_ADDR_RES: st_nxt.rdata = st_r.alu_result_reg;
            `ASDS_ADDR_FB: st_nxt.rdata = st_r.alu_feedback_reg;
            `ASDS_ADDR_FLAGS: st_nxt.rdata = {10'h000, st_r.quotient_flag, st_r.x_sign_flag,
               st_r.carry_flag, st_r.overflow_flag, st_r.negative_flag, st_r.zero_flag};
            `ASDS_ADDR_MODE: st_nxt.rdata = mw;
            default: st_nxt.rdata = 16'h0000;
         endcase
      end
   end

   // ***************************************************
   // State register
   // ***************************************************
   // Reset clears everything, modes included
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata = st_r.rdata;
   assign result_out = st_r.alu_result_reg;
   assign flags_out = {st_r.quotient_flag, st_r.x_sign_flag, st_r.carry_flag,
                       st_r.overflow_flag, st_r.negative_flag, st_r.zero_flag};
   assign sat_mode_out = st_r.result_saturation_mode;
   assign sticky_mode_out = st_r.sticky_overflow_mode;

   // ***************************************************
   // Checks
   // ***************************************************
   logic exec;
   assign exec = op_valid && op != ASDS_OP_NOP && !wr;

   property p_sat_pos;
      @(posedge mclk) disable iff (reset)
      exec && st_r.result_saturation_mode && dst == ASDS_DST_RES && arith &&
      (sum[17] ^ sum[16]) && !sum[17] && op != ASDS_OP_DIVIDE_SIGN_STEP && op != ASDS_OP_DIVIDE_QUOTIENT_STEP
      |=> st_r.alu_result_reg == `ASDS_SAT_POS;
   endproperty
   a_sat_pos: assert property (p_sat_pos) else $error("no positive saturation");

   property p_nosat;
      @(posedge mclk) disable iff (reset)
      exec && !st_r.result_saturation_mode && dst == ASDS_DST_RES &&
      op != ASDS_OP_DIVIDE_SIGN_STEP && op != ASDS_OP_DIVIDE_QUOTIENT_STEP
      |=> st_r.alu_result_reg == $past(raw);
   endproperty
   a_nosat: assert property (p_nosat) else $error("raw result altered");

   property p_sticky;
      @(posedge mclk) disable iff (reset)
      st_r.sticky_overflow_mode && st_r.overflow_flag && !wr |=> st_r.overflow_flag;
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky overflow lost");

   property p_zero;
      @(posedge mclk) disable iff (reset)
      exec && !st_r.result_saturation_mode |=> st_r.zero_flag == ($past(raw) == 16'h0000);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

   property p_quot_hold;
      @(posedge mclk) disable iff (reset)
      !wr && !(op_valid && (op == ASDS_OP_DIVIDE_SIGN_STEP || op == ASDS_OP_DIVIDE_QUOTIENT_STEP))
      |=> $stable(st_r.quotient_flag);
   endproperty
   a_quot_hold: assert property (p_quot_hold) else $error("quotient flag moved");

   property p_divide_quotient_step_bit;
      @(posedge mclk) disable iff (reset)
      exec && op == ASDS_OP_DIVIDE_QUOTIENT_STEP |=> st_r.y_operand_reg0[0] == !st_r.quotient_flag;
   endproperty
   a_divide_quotient_step_bit: assert property (p_divide_quotient_step_bit) else $error("quotient bit wrong");

   property p_divide_sign_step_pair;
      @(posedge mclk) disable iff (reset)
      exec && op == ASDS_OP_DIVIDE_SIGN_STEP
      |=> st_r.alu_feedback_reg[0] == $past(st_r.y_operand_reg0[15]) &&
          st_r.y_operand_reg0[0] == st_r.quotient_flag;
   endproperty
   a_divide_sign_step_pair: assert property (p_divide_sign_step_pair) else $error("sign step shift wrong");

   property p_modes_reset;
      @(posedge mclk) $fell(reset) |-> !st_r.result_saturation_mode &&
                                       !st_r.sticky_overflow_mode;
   endproperty
   a_modes_reset: assert property (p_modes_reset) else $error("modes on after reset");
endmodule

// ==== tb/asds_seq_model.sv ====
`timescale 1ns/1ps
// ************************************************
// Sequencer stand-in driving the ALU op port
// ************************************************
module asds_seq_model (
   input wire logic mclk,
   output logic op_valid,
   output asds_pkg::asds_op_e op,
   output asds_pkg::asds_xsel_e x_sel,
   output asds_pkg::asds_ysel_e y_sel,
   output asds_pkg::asds_dst_e dst,
   output logic [15:0] r_bus,
   output asds_pkg::asds_mc_e sat_cmd,
   output asds_pkg::asds_mc_e sticky_cmd
);
   import asds_pkg::*;
   // Idle values from time zero
   initial begin
      op_valid = 1'b0;
      op = ASDS_OP_NOP;
      x_sel = ASDS_XS_X0;
      y_sel = ASDS_YS_Y0;
      dst = ASDS_DST_NONE;
      r_bus = 16'hA5A5;
      sat_cmd = ASDS_MC_NONE;
      sticky_cmd = ASDS_MC_NONE;
   end
   // One op with X from the result bus; bus inverted once released
   task automatic issue(input asds_op_e o, input asds_ysel_e ys, input asds_dst_e d,
      input logic [15:0] xv);
      @(posedge mclk);
      op_valid <= 1'b1;
      op <= o;
      x_sel <= ASDS_XS_RB;
      y_sel <= ys;
      dst <= d;
      r_bus <= xv;
      @(posedge mclk);
      op_valid <= 1'b0;
      op <= ASDS_OP_NOP;
      r_bus <= ~xv;
   endtask
   // Divide steps back to back, no gap between primitives
   task automatic divide(input logic sgn, input asds_xsel_e xs, input asds_ysel_e ys);
      int n;
      n = sgn ? 15 : 16;
      @(posedge mclk);
      op_valid <= 1'b1;
      x_sel <= xs;
      dst <= ASDS_DST_NONE;
      if (sgn) begin
         op <= ASDS_OP_DIVIDE_SIGN_STEP;
         y_sel <= ys;
         @(posedge mclk);
      end
      for (int i = 0; i < n; i++) begin
         op <= ASDS_OP_DIVIDE_QUOTIENT_STEP;
         y_sel <= ASDS_YS_FB;
         @(posedge mclk);
      end
      op_valid <= 1'b0;
      op <= ASDS_OP_NOP;
   endtask
   // Mode command pulse, one cycle long
   task automatic mode(input asds_mc_e s, input asds_mc_e k);
      @(posedge mclk);
      sat_cmd <= s;
      sticky_cmd <= k;
      @(posedge mclk);
      sat_cmd <= ASDS_MC_NONE;
      sticky_cmd <= ASDS_MC_NONE;
   endtask
endmodule

// ==== tb/alu_saturation_divide_status_tb.sv ====
`timescale 1ns/1ps
`include "asds_regs.svh"
module alu_saturation_divide_status_tb;
   import asds_pkg::*;
   logic mclk, reset, wr, rd, op_valid, sat_mode_out, sticky_mode_out;
   logic [3:0] addr;
   logic [15:0] wdata, r_bus, rdata, result_out;
   logic [5:0] flags_out;
   asds_op_e op;
   asds_xsel_e x_sel;
   asds_ysel_e y_sel;
   asds_dst_e dst;
   asds_mc_e sat_cmd, sticky_cmd;
   int mismatches, checks;
   logic cy, qf, xsf;
   asds_alu i_dut (.mclk(mclk), .reset(reset), .op_valid(op_valid), .op(op), .x_sel(x_sel),
      .y_sel(y_sel), .dst(dst), .r_bus(r_bus), .sat_cmd(sat_cmd), .sticky_cmd(sticky_cmd),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .result_out(result_out),
      .flags_out(flags_out), .sat_mode_out(sat_mode_out), .sticky_mode_out(sticky_mode_out));
   asds_seq_model i_seq (.mclk(mclk), .op_valid(op_valid), .op(op), .x_sel(x_sel),
      .y_sel(y_sel), .dst(dst), .r_bus(r_bus), .sat_cmd(sat_cmd), .sticky_cmd(sticky_cmd));
   // ************************************************
   // Helpers
   // ************************************************
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Adder reference: {carry, overflow, sum}
   function automatic logic [17:0] add_ref(input logic [15:0] a, input logic [15:0] b,
      input logic ci);
      logic [16:0] s;
      logic [15:0] lo;
      lo = {1'b0, a[14:0]} + {1'b0, b[14:0]} + {15'h0000, ci};
      s = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
      return {s[16], s[16] ^ lo[15], s[15:0]};
   endfunction
   function automatic logic [5:0] fl(input logic [15:0] r, input logic v, input logic c);
      return {qf, xsf, c, v, r[15], ~|r};
   endfunction
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic chk_flags(input logic [5:0] got, input logic [5:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: flags got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Register port: strobe one cycle, read data only in the next cycle
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   // ************************************************
   // Scenarios
   // ************************************************
   task automatic t_reset();
      logic [15:0] v;
      chk_word({12'h000, sat_mode_out, sticky_mode_out, flags_out[5:4]}, 16'h0000, "modes");
      rd_reg(`ASDS_ADDR_MODE, v);
      chk_word(v, 16'h0000, "mode reg");
      wr_reg(4'hF, 16'hFFFF);
      rd_reg(4'hF, v);
      chk_word(v, 16'h0000, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_arith();
      asds_op_e ops [6] = '{ASDS_OP_ADD, ASDS_OP_ADDC, ASDS_OP_SUB, ASDS_OP_SUBB,
         ASDS_OP_RSUB, ASDS_OP_RSUBB};
      logic [15:0] xv [6] = '{16'hFFFF, 16'h0000, 16'h0005, 16'h0003, 16'h0001, 16'h0002};
      logic [15:0] yv [6] = '{16'h0001, 16'h0000, 16'h0003, 16'h0005, 16'h8000, 16'h0001};
      logic [17:0] e;
      for (int i = 0; i < 6; i++) begin
         wr_reg(`ASDS_ADDR_Y0, yv[i]);
         i_seq.issue(ops[i], ASDS_YS_Y0, ASDS_DST_RES, xv[i]);
         #1;
         case (i)
            0: e = add_ref(xv[i], yv[i], 1'b0);
            1: e = add_ref(xv[i], yv[i], cy);
            2: e = add_ref(xv[i], ~yv[i], 1'b1);
            3: e = add_ref(xv[i], ~yv[i], cy);
            4: e = add_ref(yv[i], ~xv[i], 1'b1);
            default: e = add_ref(yv[i], ~xv[i], cy);
         endcase
         cy = e[17];
         chk_word(result_out, e[15:0], "arith result");
         chk_flags(flags_out, fl(e[15:0], e[16], e[17]));
      end
      $display("test arith done");
   endtask
   task automatic t_sat();
      logic [15:0] v;
      i_seq.mode(ASDS_MC_SET, ASDS_MC_NONE);
      #1;
      chk_word({15'h0000, sat_mode_out}, 16'h0001, "sat on");
      wr_reg(`ASDS_ADDR_Y0, 16'h0001);
      i_seq.issue(ASDS_OP_ADD, ASDS_YS_Y0, ASDS_DST_RES, 16'h7FFF);
      #1;
      chk_word(result_out, 16'h7FFF, "sat positive");
      chk_flags(flags_out, fl(16'h7FFF, 1'b1, 1'b0));
      wr_reg(`ASDS_ADDR_Y0, 16'h8000);
      i_seq.issue(ASDS_OP_ADD, ASDS_YS_Y0, ASDS_DST_RES, 16'h8000);
      #1;
      chk_word(result_out, 16'h8000, "sat negative");
      i_seq.issue(ASDS_OP_ADD, ASDS_YS_Y0, ASDS_DST_FB, 16'h8001);
      #1;
      chk_flags(flags_out, fl(16'h8000, 1'b1, 1'b1));
      rd_reg(`ASDS_ADDR_FB, v);
      chk_word(v, 16'h0001, "feedback wraps");
      chk_word(result_out, 16'h8000, "result kept");
      wr_reg(`ASDS_ADDR_MODE, 16'h0000);
      i_seq.issue(ASDS_OP_ADD, ASDS_YS_Y0, ASDS_DST_RES, 16'h8000);
      #1;
      chk_word(result_out, 16'h0000, "raw wrap");
      wr_reg(`ASDS_ADDR_MODE, 16'h0008);
      rd_reg(`ASDS_ADDR_MODE, v);
      chk_word(v, 16'h0008, "sat bit");
      wr_reg(`ASDS_ADDR_MODE, 16'h0000);
      $display("test saturation done");
   endtask
   task automatic t_sticky();
      logic [15:0] v;
      i_seq.mode(ASDS_MC_NONE, ASDS_MC_SET);
      #1;
      chk_word({15'h0000, sticky_mode_out}, 16'h0001, "sticky on");
      wr_reg(`ASDS_ADDR_Y0, 16'h0001);
      i_seq.issue(ASDS_OP_ADD, ASDS_YS_Y0, ASDS_DST_RES, 16'h7FFF);
      i_seq.issue(ASDS_OP_ADD, ASDS_YS_Y0, ASDS_DST_RES, 16'h0001);
      #1;
      chk_word({15'h0000, flags_out[2]}, 16'h0001, "ovf held");
      wr_reg(`ASDS_ADDR_FLAGS, 16'h0000);
      {cy, qf, xsf} = 3'b000;
      #1;
      chk_flags(flags_out, 6'h00);
      i_seq.issue(ASDS_OP_ADD, ASDS_YS_Y0, ASDS_DST_RES, 16'h0001);
      #1;
      chk_flags(flags_out, fl(16'h0002, 1'b0, 1'b0));
      i_seq.mode(ASDS_MC_NONE, ASDS_MC_CLEAR);
      #1;
      chk_word({15'h0000, sticky_mode_out}, 16'h0000, "sticky off");
      wr_reg(`ASDS_ADDR_MODE, 16'h0004);
      rd_reg(`ASDS_ADDR_MODE, v);
      chk_word(v, 16'h0004, "sticky bit");
      wr_reg(`ASDS_ADDR_MODE, 16'h0000);
      $display("test sticky done");
   endtask
   task automatic t_abs();
      i_seq.issue(ASDS_OP_ABSX, ASDS_YS_Y0, ASDS_DST_RES, 16'h8003);
      #1;
      chk_word(result_out, 16'h7FFD, "abs");
      chk_word({14'h0000, flags_out[5:4]}, 16'h0001, "xsign set");
      i_seq.issue(ASDS_OP_ADD, ASDS_YS_Y0, ASDS_DST_RES, 16'h0005);
      #1;
      chk_word({14'h0000, flags_out[5:4]}, 16'h0001, "xsign kept");
      i_seq.issue(ASDS_OP_ABSX, ASDS_YS_Y0, ASDS_DST_RES, 16'h0005);
      #1;
      chk_word({15'h0000, flags_out[4]}, 16'h0000, "xsign clear");
      $display("test abs done");
   endtask
   // Remaining functions; each value differs from the one before it
   task automatic t_ops();
      asds_op_e ops [12] = '{ASDS_OP_NEGX, ASDS_OP_NEGY, ASDS_OP_INCY, ASDS_OP_DECY,
         ASDS_OP_PASSX, ASDS_OP_PASSY, ASDS_OP_ZERO, ASDS_OP_AND, ASDS_OP_OR, ASDS_OP_XOR,
         ASDS_OP_NOTX, ASDS_OP_NOTY};
      logic [15:0] ev [12] = '{16'hF010, 16'hF0F1, 16'h0F10, 16'h0F0E, 16'h0FF0, 16'h0F0F,
         16'h0000, 16'h0F00, 16'h0FFF, 16'h00FF, 16'hF00F, 16'hF0F0};
      wr_reg(`ASDS_ADDR_Y0, 16'h0F0F);
      for (int i = 0; i < 12; i++) begin
         i_seq.issue(ops[i], ASDS_YS_Y0, ASDS_DST_RES, 16'h0FF0);
         #1;
         chk_word(result_out, ev[i], "function result");
      end
      $display("test functions done");
   endtask
   // Non-restoring divide against a step-by-step reference
   task automatic t_div(input logic sgn, input logic [15:0] d, input logic [15:0] hi,
      input logic [15:0] lo);
      logic [15:0] af, ay, r, v;
      logic aq;
      wr_reg(sgn ? `ASDS_ADDR_X1 : `ASDS_ADDR_X0, d);
      wr_reg(sgn ? `ASDS_ADDR_Y1 : `ASDS_ADDR_FB, hi);
      wr_reg(`ASDS_ADDR_Y0, lo);
      wr_reg(`ASDS_ADDR_FLAGS, 16'h0000);
      i_seq.divide(sgn, sgn ? ASDS_XS_X1 : ASDS_XS_X0, ASDS_YS_Y1);
      af = hi;
      ay = lo;
      aq = 1'b0;
      if (sgn) begin
         aq = d[15] ^ hi[15];
         af = {hi[14:0], lo[15]};
         ay = {lo[14:0], aq};
      end
      for (int i = 0; i < (sgn ? 15 : 16); i++) begin
         r = aq ? af + d : af - d;
         af = {r[14:0], ay[15]};
         aq = d[15] ^ r[15];
         ay = {ay[14:0], ~aq};
      end
      rd_reg(`ASDS_ADDR_Y0, v);
      chk_word(v, ay, "quotient");
      chk_word({15'h0000, flags_out[5]}, {15'h0000, aq}, "quotient flag");
      rd_reg(`ASDS_ADDR_FB, v);
      chk_word(v, af, "remainder");
      $display("test divide done");
   endtask
   // ************************************************
   // Main sequence and watchdog
   // ************************************************
   initial begin
      reset = 1'b1;
      {wr, rd, addr, wdata} = 22'h000000;
      {mismatches, checks} = 64'h0;
      {cy, qf, xsf} = 3'b000;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_arith();
      t_sat();
      t_sticky();
      t_abs();
      t_ops();
      t_div(1'b0, 16'h0007, 16'h0000, 16'h00C8);
      t_div(1'b1, 16'h0007, 16'hFFFF, 16'hFF38);
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      $display("unexpected at %0t: run hung", $time);
      finish_test();
   end
endmodule
